// ==== rtl/addr_gen_pkg.sv ====
// Constants, modes and carriers for the operand address generator
package addr_gen_pkg;

    // =========================================================
    // Address map
    localparam logic [6:0] SHORT_HIGH_BITS = 7'h7F;
    localparam logic [7:0] SHORT_SPLIT = 8'h20;
    localparam logic [7:0] SFR_PAGE = 8'hFF;
    localparam logic [15:0] SHORT_LOW = 16'hFE20;
    localparam logic [15:0] SHORT_HIGH = 16'hFF1F;
    localparam logic [15:0] SFR_LOW = 16'hFF00;
    localparam logic [15:0] RAM_LOW = 16'hFE00;
    localparam logic [15:0] RAM_HIGH = 16'hFEFF;

    // =========================================================
    // Reset values
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'hFF00;
    localparam logic [7:0] REG_RESET = 8'h00;

    // =========================================================
    // Register file shape and pair indices
    localparam int REG_COUNT = 8;
    localparam int REG_WIDTH = 8;
    localparam logic [1:0] ACC_PAIR = 2'h0;
    localparam logic [1:0] COUNT_PAIR = 2'h1;
    localparam logic [1:0] INDEX_PAIR = 2'h2;
    localparam logic [1:0] BASE_PAIR = 2'h3;

    // =========================================================
    // Addressing modes
    typedef enum logic [3:0] {
        MODE_DIRECT,
        MODE_SHORT,
        MODE_SHORT_WORD,
        MODE_SFR,
        MODE_REG,
        MODE_PAIR,
        MODE_INDIRECT,
        MODE_BASED,
        MODE_PUSH,
        MODE_POP
    } mode_t;

    // Memory space of a formed address
    typedef enum logic [1:0] {
        SPACE_OTHER,
        SPACE_RAM,
        SPACE_SFR
    } space_t;

    // Request from the instruction decoder
    typedef struct packed {
        logic valid;
        mode_t mode;
        logic [15:0] imm16;
        logic [7:0] imm8;
        logic [2:0] reg_code;
        logic [1:0] pair_code;
        logic use_base;
    } req_t;

    // Answer towards the RAM and SFR bus
    typedef struct packed {
        logic valid;
        logic error;
        space_t space;
        logic [15:0] addr;
        logic [7:0] reg_data;
        logic [15:0] pair_data;
    } resp_t;

endpackage : addr_gen_pkg

// ==== rtl/gp_register_file.sv ====
// Eight general-purpose byte registers with a registered read port
`timescale 1ns/1ps
`default_nettype none
module gp_register_file #(
    parameter int COUNT = addr_gen_pkg::REG_COUNT,
    parameter int WIDTH = addr_gen_pkg::REG_WIDTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wr_en,
    input wire logic [$clog2(COUNT)-1:0] wr_index,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [$clog2(COUNT)-1:0] rd_index,
    output logic [WIDTH-1:0] rd_data,
    output logic [COUNT*WIDTH-1:0] contents
);

    logic [WIDTH-1:0] store [COUNT];

    // Storage writes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < COUNT; i++) begin
                store[i] <= WIDTH'(addr_gen_pkg::REG_RESET);
            end
        end else if (wr_en) begin
            store[wr_index] <= wr_data;
        end
    end

    // Registered byte read
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= WIDTH'(addr_gen_pkg::REG_RESET);
        end else begin
            rd_data <= store[rd_index];
        end
    end

    // Flat view of all registers
    always_comb begin
        for (int i = 0; i < COUNT; i++) begin
            contents[i*WIDTH +: WIDTH] = store[i];
        end
    end

endmodule : gp_register_file
`default_nettype wire

// ==== rtl/operand_address_generator.sv ====
// Operand address, stack pointer and program counter generation
`timescale 1ns/1ps
`default_nettype none
module operand_address_generator (
    input wire logic clk,
    input wire logic reset_n,
    input wire addr_gen_pkg::req_t req,
    input wire logic reg_wr_en,
    input wire logic [2:0] reg_wr_index,
    input wire logic [7:0] reg_wr_data,
    input wire logic sp_load,
    input wire logic [15:0] sp_load_value,
    input wire logic fetch_byte,
    input wire logic register_pair_jump,
    output addr_gen_pkg::resp_t resp,
    output logic [15:0] stack_pointer,
    output logic [15:0] program_counter
);

    // =========================================================
    // Helpers

    // Short direct address: fixed high bits, bit 8 from field range
    function automatic logic [15:0] short_addr(input logic [7:0] field);
        short_addr = {addr_gen_pkg::SHORT_HIGH_BITS,
                      field < addr_gen_pkg::SHORT_SPLIT, field};
    endfunction : short_addr

    // Memory space of an address
    function automatic addr_gen_pkg::space_t space_of(input logic [15:0] a);
        if (a >= addr_gen_pkg::SFR_LOW) begin
            space_of = addr_gen_pkg::SPACE_SFR;
        end else if (a >= addr_gen_pkg::RAM_LOW) begin
            space_of = addr_gen_pkg::SPACE_RAM;
        end else begin
            space_of = addr_gen_pkg::SPACE_OTHER;
        end
    endfunction : space_of

    // =========================================================
    // Register file and pair views
    logic [63:0] contents;
    logic [7:0] reg_byte;
    logic [15:0] pair [4];
    logic [15:0] acc_pair;
    logic [15:0] base_pair;
    logic [15:0] index_pair;
    logic [15:0] sel_pair;

    gp_register_file #(
        .COUNT(addr_gen_pkg::REG_COUNT),
        .WIDTH(addr_gen_pkg::REG_WIDTH)
    ) u_regs (
        .clk(clk),
        .reset_n(reset_n),
        .wr_en(reg_wr_en),
        .wr_index(reg_wr_index),
        .wr_data(reg_wr_data),
        .rd_index(req.reg_code),
        .rd_data(reg_byte),
        .contents(contents)
    );

    // Pair n joins register 2n+1 (high) and 2n (low)
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            pair[n] = contents[n*16 +: 16];
        end
    end

    assign acc_pair = pair[addr_gen_pkg::ACC_PAIR];
    assign base_pair = pair[addr_gen_pkg::BASE_PAIR];
    assign index_pair = pair[addr_gen_pkg::INDEX_PAIR];
    assign sel_pair = pair[req.pair_code];

    // =========================================================
    // Address formation
    logic [15:0] sp_dec;
    logic [15:0] sp_inc;
    logic [15:0] based_sum;
    logic [15:0] indirect_addr;
    logic is_stack;
    logic odd_word;
    logic [15:0] next_addr;
    logic next_valid;
    logic next_error;
    addr_gen_pkg::space_t next_space;

    assign sp_dec = stack_pointer - 16'h0001;
    assign sp_inc = stack_pointer + 16'h0001;
    assign based_sum = base_pair + {8'h00, req.imm8};
    assign indirect_addr = req.use_base ? base_pair : index_pair;
    assign is_stack = req.mode inside {addr_gen_pkg::MODE_PUSH,
                                       addr_gen_pkg::MODE_POP};
    assign odd_word = (req.mode == addr_gen_pkg::MODE_SHORT_WORD) && req.imm8[0];

    // Address per mode
    always_comb begin
        unique case (req.mode)
            addr_gen_pkg::MODE_DIRECT: next_addr = req.imm16;
            addr_gen_pkg::MODE_SHORT: next_addr = short_addr(req.imm8);
            addr_gen_pkg::MODE_SHORT_WORD: next_addr = short_addr(req.imm8);
            addr_gen_pkg::MODE_SFR: next_addr = {addr_gen_pkg::SFR_PAGE, req.imm8};
            addr_gen_pkg::MODE_INDIRECT: next_addr = indirect_addr;
            addr_gen_pkg::MODE_BASED: next_addr = based_sum;
            addr_gen_pkg::MODE_PUSH: next_addr = sp_dec;
            addr_gen_pkg::MODE_POP: next_addr = stack_pointer;
            default: next_addr = 16'h0000; // register modes and illegal codes
        endcase
    end

    // Space, refusal of odd word and stack outside RAM
    assign next_space = (req.mode inside {addr_gen_pkg::MODE_REG, addr_gen_pkg::MODE_PAIR})
        ? addr_gen_pkg::SPACE_OTHER : space_of(next_addr);
    assign next_error = req.valid && (odd_word ||
        (is_stack && next_space != addr_gen_pkg::SPACE_RAM));
    assign next_valid = req.valid && !next_error;

    // =========================================================
    // Answer register
    logic ans_valid;
    logic ans_error;
    addr_gen_pkg::space_t ans_space;
    logic [15:0] ans_addr;
    logic [15:0] ans_pair;

    // Registered answer fields; one driver per field of the bus word
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ans_valid <= 1'b0;
            ans_error <= 1'b0;
            ans_space <= addr_gen_pkg::SPACE_OTHER;
            ans_addr <= 16'h0000;
            ans_pair <= 16'h0000;
        end else begin
            ans_valid <= next_valid;
            ans_error <= next_error;
            ans_space <= next_space;
            ans_addr <= next_addr;
            ans_pair <= sel_pair;
        end
    end

    // Register operand comes from the file's registered read port
    assign resp = '{valid: ans_valid, error: ans_error, space: ans_space, addr: ans_addr,
                    reg_data: reg_byte, pair_data: ans_pair};

    // =========================================================
    // Stack pointer
    logic [15:0] next_sp;

    // Load wins; refused stack ops leave the pointer alone
    always_comb begin
        next_sp = stack_pointer;
        if (sp_load) begin
            next_sp = sp_load_value;
        end else if (next_valid && req.mode == addr_gen_pkg::MODE_PUSH) begin
            next_sp = sp_dec;
        end else if (next_valid && req.mode == addr_gen_pkg::MODE_POP) begin
            next_sp = sp_inc;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stack_pointer <= addr_gen_pkg::SP_RESET;
        end else begin
            stack_pointer <= next_sp;
        end
    end

    // =========================================================
    // Program counter
    logic [15:0] next_pc;

    assign next_pc = register_pair_jump ? acc_pair
        : fetch_byte ? program_counter + 16'h0001
        : program_counter;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            program_counter <= addr_gen_pkg::PC_RESET;
        end else begin
            program_counter <= next_pc;
        end
    end

    // =========================================================
    // Checks
    property p_jump;
        @(posedge clk) disable iff (!reset_n)
        register_pair_jump |=> program_counter == $past(acc_pair);
    endproperty
    a_jump: assert property (p_jump) else $error("jump target wrong");

    property p_fetch;
        @(posedge clk) disable iff (!reset_n)
        fetch_byte && !register_pair_jump |=>
            program_counter == $past(program_counter) + 16'h0001;
    endproperty
    a_fetch: assert property (p_fetch) else $error("counter not advanced");

    property p_direct;
        @(posedge clk) disable iff (!reset_n)
        req.valid && req.mode == addr_gen_pkg::MODE_DIRECT |=>
            resp.valid && resp.addr == $past(req.imm16);
    endproperty
    a_direct: assert property (p_direct) else $error("direct address wrong");

    property p_short;
        @(posedge clk) disable iff (!reset_n)
        req.valid && req.mode == addr_gen_pkg::MODE_SHORT |=>
            resp.addr >= addr_gen_pkg::SHORT_LOW && resp.addr <= addr_gen_pkg::SHORT_HIGH
            && resp.addr[8] == ($past(req.imm8) < 8'h20)
            && resp.addr[7:0] == $past(req.imm8);
    endproperty
    a_short: assert property (p_short) else $error("short address wrong");

    property p_short_space;
        @(posedge clk) disable iff (!reset_n)
        req.valid && req.mode == addr_gen_pkg::MODE_SHORT |=>
            (resp.space == addr_gen_pkg::SPACE_RAM) == (resp.addr <= addr_gen_pkg::RAM_HIGH);
    endproperty
    a_short_space: assert property (p_short_space) else $error("short space wrong");

    property p_odd_word;
        @(posedge clk) disable iff (!reset_n)
        req.valid && req.mode == addr_gen_pkg::MODE_SHORT_WORD && req.imm8[0] |=>
            resp.error && !resp.valid;
    endproperty
    a_odd_word: assert property (p_odd_word) else $error("odd word accepted");

    property p_sfr;
        @(posedge clk) disable iff (!reset_n)
        req.valid && req.mode == addr_gen_pkg::MODE_SFR |=>
            resp.addr == {8'hFF, $past(req.imm8)} && resp.space == addr_gen_pkg::SPACE_SFR;
    endproperty
    a_sfr: assert property (p_sfr) else $error("sfr address wrong");

    property p_reg;
        @(posedge clk) disable iff (!reset_n)
        req.valid && req.mode == addr_gen_pkg::MODE_REG && !reg_wr_en |=>
            resp.reg_data == $past(contents[req.reg_code*8 +: 8]);
    endproperty
    a_reg: assert property (p_reg) else $error("register select wrong");

    property p_pair;
        @(posedge clk) disable iff (!reset_n)
        req.valid && req.mode == addr_gen_pkg::MODE_PAIR |=>
            resp.pair_data == $past({contents[req.pair_code*16 + 8 +: 8],
                                     contents[req.pair_code*16 +: 8]});
    endproperty
    a_pair: assert property (p_pair) else $error("pair select wrong");

    property p_indirect;
        @(posedge clk) disable iff (!reset_n)
        req.valid && req.mode == addr_gen_pkg::MODE_INDIRECT |=>
            resp.addr == ($past(req.use_base) ? $past(base_pair) : $past(index_pair));
    endproperty
    a_indirect: assert property (p_indirect) else $error("indirect address wrong");

    property p_based;
        @(posedge clk) disable iff (!reset_n)
        req.valid && req.mode == addr_gen_pkg::MODE_BASED |=>
            resp.addr == 16'($past(base_pair) + $past(req.imm8));
    endproperty
    a_based: assert property (p_based) else $error("based address wrong");

    property p_push;
        @(posedge clk) disable iff (!reset_n)
        next_valid && req.mode == addr_gen_pkg::MODE_PUSH && !sp_load |=>
            stack_pointer == $past(stack_pointer) - 16'h0001 && resp.addr == stack_pointer;
    endproperty
    a_push: assert property (p_push) else $error("push pointer wrong");

    property p_stack_ram;
        @(posedge clk) disable iff (!reset_n)
        resp.valid && $past(is_stack) |->
            resp.space == addr_gen_pkg::SPACE_RAM && resp.addr[15:8] == 8'hFE;
    endproperty
    a_stack_ram: assert property (p_stack_ram) else $error("stack left RAM");

    property p_pop;
        @(posedge clk) disable iff (!reset_n)
        next_valid && req.mode == addr_gen_pkg::MODE_POP && !sp_load |=>
            stack_pointer == $past(stack_pointer) + 16'h0001
            && resp.addr == $past(stack_pointer);
    endproperty
    a_pop: assert property (p_pop) else $error("pop pointer wrong");

    property p_sp_load;
        @(posedge clk) disable iff (!reset_n)
        sp_load |=> stack_pointer == $past(sp_load_value);
    endproperty
    a_sp_load: assert property (p_sp_load) else $error("pointer load lost");

    property p_stack_refuse;
        @(posedge clk) disable iff (!reset_n)
        req.valid && !sp_load
            && ((req.mode == addr_gen_pkg::MODE_POP && stack_pointer[15:8] != 8'hFE)
            || (req.mode == addr_gen_pkg::MODE_PUSH && sp_dec[15:8] != 8'hFE)) |=>
            resp.error && !resp.valid && stack_pointer == $past(stack_pointer);
    endproperty
    a_stack_refuse: assert property (p_stack_refuse) else $error("stack op outside RAM taken");

    property p_word_even;
        @(posedge clk) disable iff (!reset_n)
        req.valid && req.mode == addr_gen_pkg::MODE_SHORT_WORD && !req.imm8[0] |=>
            resp.valid && !resp.addr[0] && resp.addr[7:0] == $past(req.imm8);
    endproperty
    a_word_even: assert property (p_word_even) else $error("even word refused");

    property p_pc_hold;
        @(posedge clk) disable iff (!reset_n)
        !fetch_byte && !register_pair_jump |=> $stable(program_counter);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("counter moved while idle");

endmodule : operand_address_generator
`default_nettype wire

// ==== test/ram_sfr_bus_model.sv ====
// Far-side model of the internal RAM and SFR bus: counts answers routed to the wrong space
`timescale 1ns/1ps
`default_nettype none
module ram_sfr_bus_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire addr_gen_pkg::resp_t resp,
    output logic [15:0] bad_space
);
    // =========================================================
    // Address decode of the far side
    logic in_ram;
    logic in_sfr;
    logic wrong;
    // High-speed RAM page and SFR page as the bus sees them
    assign in_ram = (resp.addr[15:8] == 8'hFE);
    assign in_sfr = (resp.addr[15:8] == 8'hFF);
    // A RAM or SFR tag on an address outside that page is a routing fault
    assign wrong = resp.valid
        && (((resp.space == addr_gen_pkg::SPACE_RAM) && !in_ram)
        || ((resp.space == addr_gen_pkg::SPACE_SFR) && !in_sfr));

    // =========================================================
    // Fault counter, read by the bench at the end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bad_space <= 16'h0000;
        end else if (wrong) begin
            bad_space <= bad_space + 16'h0001;
        end
    end
endmodule : ram_sfr_bus_model
`default_nettype wire

// ==== test/operand_address_generator_tb.sv ====
// Self-checking testbench for the operand address generator
`timescale 1ns/1ps
`default_nettype none
module operand_address_generator_tb;
    logic clk;
    logic reset_n;
    addr_gen_pkg::req_t req;
    logic reg_wr_en;
    logic [2:0] reg_wr_index;
    logic [7:0] reg_wr_data;
    logic sp_load;
    logic [15:0] sp_load_value;
    logic fetch_byte;
    logic register_pair_jump;
    addr_gen_pkg::resp_t resp;
    logic [15:0] stack_pointer;
    logic [15:0] program_counter;
    logic [15:0] bad_space;
    logic [7:0] regs [8];
    int n_fail;
    int comparisons;

    operand_address_generator operand_address_generator_i (.clk(clk), .reset_n(reset_n),
        .req(req), .reg_wr_en(reg_wr_en), .reg_wr_index(reg_wr_index),
        .reg_wr_data(reg_wr_data), .sp_load(sp_load), .sp_load_value(sp_load_value),
        .fetch_byte(fetch_byte), .register_pair_jump(register_pair_jump), .resp(resp),
        .stack_pointer(stack_pointer), .program_counter(program_counter));
    ram_sfr_bus_model ram_sfr_bus_model_i (.clk(clk), .reset_n(reset_n), .resp(resp),
        .bad_space(bad_space));

    // =========================================================
    // Clock at 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // =========================================================
    // Shared tasks
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expected);
        comparisons++;
        if (seen !== expected) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, expected, seen);
        end
    endtask : check

    // One request; sel feeds imm8, reg_code, pair_code and use_base from its low bits
    task automatic issue(input addr_gen_pkg::mode_t mode, input logic [15:0] imm16,
                         input logic [7:0] sel);
        @(posedge clk);
        req.valid <= 1'b1;
        req.mode <= mode;
        req.imm16 <= imm16;
        req.imm8 <= sel;
        req.reg_code <= sel[2:0];
        req.pair_code <= sel[1:0];
        req.use_base <= sel[0];
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
    endtask : issue

    task automatic wr_reg(input logic [2:0] idx, input logic [7:0] data);
        @(posedge clk);
        reg_wr_en <= 1'b1;
        reg_wr_index <= idx;
        reg_wr_data <= data;
        @(posedge clk);
        reg_wr_en <= 1'b0;
        regs[idx] = data;
    endtask : wr_reg

    task automatic load_sp(input logic [15:0] value);
        @(posedge clk);
        sp_load <= 1'b1;
        sp_load_value <= value;
        @(posedge clk);
        sp_load <= 1'b0;
        #1;
        check("sp_load", stack_pointer, value);
    endtask : load_sp

    task automatic expect_ok(input string name, input logic [15:0] addr, input logic [1:0] space);
        check({name, " valid"}, {14'h0000, resp.error, resp.valid}, 16'h0001);
        check({name, " addr"}, resp.addr, addr);
        check({name, " space"}, {14'h0000, resp.space}, {14'h0000, space});
    endtask : expect_ok

    // =========================================================
    // Scenarios
    task automatic t_reset;
        check("sp reset", stack_pointer, 16'hFF00);
        check("pc reset", program_counter, 16'h0000);
        check("resp reset", {15'h0000, resp.valid}, 16'h0000);
    endtask : t_reset

    task automatic t_direct;
        issue(addr_gen_pkg::MODE_DIRECT, 16'hA5C3, 8'h00);
        check("direct", resp.addr, 16'hA5C3);
        issue(addr_gen_pkg::MODE_DIRECT, 16'h0001, 8'h00);
        check("direct low", resp.addr, 16'h0001);
    endtask : t_direct

    task automatic t_short;
        logic [7:0] f [5] = '{8'h00, 8'h1F, 8'h20, 8'h10, 8'hFF};
        foreach (f[i]) begin
            issue(addr_gen_pkg::MODE_SHORT, 16'h0000, f[i]);
            expect_ok("short", {7'h7F, f[i] < 8'h20, f[i]},
                (f[i] < 8'h20) ? 2'h2 : 2'h1);
        end
    endtask : t_short

    task automatic t_short_word;
        logic [7:0] f [4] = '{8'h20, 8'h21, 8'h1E, 8'h1F};
        foreach (f[i]) begin
            issue(addr_gen_pkg::MODE_SHORT_WORD, 16'h0000, f[i]);
            check("word refuse", {14'h0000, resp.error, resp.valid}, f[i][0] ? 16'h0002 : 16'h0001);
            if (!f[i][0]) begin
                check("word addr", resp.addr, {7'h7F, f[i] < 8'h20, f[i]});
            end
        end
    endtask : t_short_word

    task automatic t_sfr;
        logic [7:0] f [4] = '{8'h00, 8'h1F, 8'h20, 8'hFF};
        foreach (f[i]) begin
            issue(addr_gen_pkg::MODE_SFR, 16'h0000, f[i]);
            expect_ok("sfr", {8'hFF, f[i]}, 2'h2);
        end
    endtask : t_sfr

    task automatic t_regs;
        for (int i = 0; i < 8; i++) begin
            wr_reg(3'(i), {4'(i), 4'(~i)});
        end
        for (int i = 0; i < 8; i++) begin
            issue(addr_gen_pkg::MODE_REG, 16'h0000, 8'(i));
            check("reg read", {8'h00, resp.reg_data}, {8'h00, regs[i]});
        end
        for (int p = 0; p < 4; p++) begin
            issue(addr_gen_pkg::MODE_PAIR, 16'h0000, 8'(p));
            check("pair read", resp.pair_data, {regs[2*p+1], regs[2*p]});
        end
        issue(addr_gen_pkg::MODE_INDIRECT, 16'h0000, 8'h00);
        expect_ok("index ind", {regs[5], regs[4]}, 2'h0);
        issue(addr_gen_pkg::MODE_INDIRECT, 16'h0000, 8'h01);
        expect_ok("base ind", {regs[7], regs[6]}, 2'h0);
    endtask : t_regs

    task automatic t_based;
        logic [7:0] off [3] = '{8'h20, 8'h80, 8'h0F};
        wr_reg(3'h7, 8'hFF);
        wr_reg(3'h6, 8'hF0);
        foreach (off[i]) begin
            issue(addr_gen_pkg::MODE_BASED, 16'h0000, off[i]);
            check("based", resp.addr, 16'hFFF0 + {8'h00, off[i]});
        end
    endtask : t_based

    task automatic t_stack;
        load_sp(16'hFF00);
        issue(addr_gen_pkg::MODE_PUSH, 16'h0000, 8'h00);
        expect_ok("push", 16'hFEFF, 2'h1);
        check("push sp", stack_pointer, 16'hFEFF);
        issue(addr_gen_pkg::MODE_POP, 16'h0000, 8'h00);
        expect_ok("pop", 16'hFEFF, 2'h1);
        check("pop sp", stack_pointer, 16'hFF00);
        issue(addr_gen_pkg::MODE_POP, 16'h0000, 8'h00);
        check("pop out", {14'h0000, resp.error, resp.valid}, 16'h0002);
        check("pop out sp", stack_pointer, 16'hFF00);
        load_sp(16'hFE00);
        issue(addr_gen_pkg::MODE_PUSH, 16'h0000, 8'h00);
        check("push out", {14'h0000, resp.error, resp.valid}, 16'h0002);
        check("push out sp", stack_pointer, 16'hFE00);
        issue(addr_gen_pkg::MODE_POP, 16'h0000, 8'h00);
        expect_ok("pop low", 16'hFE00, 2'h1);
        check("pop low sp", stack_pointer, 16'hFE01);
    endtask : t_stack

    task automatic t_pc;
        logic [15:0] start;
        wr_reg(3'h0, 8'h34);
        wr_reg(3'h1, 8'h12);
        #1;
        start = program_counter;
        @(posedge clk);
        fetch_byte <= 1'b1;
        repeat (3) @(posedge clk);
        fetch_byte <= 1'b0;
        #1;
        check("pc fetch", program_counter, start + 16'h0003);
        @(posedge clk);
        fetch_byte <= 1'b1;
        register_pair_jump <= 1'b1;
        @(posedge clk);
        register_pair_jump <= 1'b0;
        @(posedge clk);
        fetch_byte <= 1'b0;
        #1;
        check("pc jump", program_counter, 16'h1235);
    endtask : t_pc

    task automatic finish_test;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    // =========================================================
    // Watchdog, far beyond the hundred or so cycles the run needs
    initial begin
        #100000;
        n_fail++;
        finish_test();
    end

    // =========================================================
    // Main sequence
    initial begin
        n_fail = 0;
        comparisons = 0;
        req = '0;
        reg_wr_en = 1'b0;
        reg_wr_index = 3'h0;
        reg_wr_data = 8'h00;
        sp_load = 1'b0;
        sp_load_value = 16'h0000;
        fetch_byte = 1'b0;
        register_pair_jump = 1'b0;
        reset_n = 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        t_reset();
        t_direct();
        t_short();
        t_short_word();
        t_sfr();
        t_regs();
        t_based();
        t_stack();
        t_pc();
        check("bus space", bad_space, 16'h0000);
        finish_test();
    end
endmodule : operand_address_generator_tb
`default_nettype wire
